/* File: hw/lane_channel_config_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module lane_channel_config_registers #(
  parameter logic [6:0] BUS_ADDR        = lane_cfg_pkg::DEF_BUS_ADDR,
  parameter int         INTERVAL_CYCLES = lane_cfg_pkg::DETECT_INTERVAL_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic              line_signal_present,
  input  wire logic              far_end_sense,
  input  wire logic [1:0]        rate_detect_pins,
  output logic                   output_mute,
  output logic                   rx_probe,
  output logic                   term_50_ohm,
  output lane_cfg_pkg::lane_cfg_t cfg
);

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_ACK   = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ  = 6'h10,
    ST_RACK  = 6'h20
  } bus_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic       scl_s1, scl_s2, scl_p;
  logic       sda_s1, sda_s2, sda_p;
  logic       sig_s1, sig_s2;
  logic       sense_s1, sense_s2;
  logic [1:0] rate_s1, rate_s2;

  // Two flops per pin, plus one history stage for edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1   <= 1'b1;
      scl_s2   <= 1'b1;
      scl_p    <= 1'b1;
      sda_s1   <= 1'b1;
      sda_s2   <= 1'b1;
      sda_p    <= 1'b1;
      sig_s1   <= 1'b0;
      sig_s2   <= 1'b0;
      sense_s1 <= 1'b0;
      sense_s2 <= 1'b0;
      rate_s1  <= 2'h0;
      rate_s2  <= 2'h0;
    end else begin
      scl_s1   <= scl_in;
      scl_s2   <= scl_s1;
      scl_p    <= scl_s2;
      sda_s1   <= sda_in;
      sda_s2   <= sda_s1;
      sda_p    <= sda_s2;
      sig_s1   <= line_signal_present;
      sig_s2   <= sig_s1;
      sense_s1 <= far_end_sense;
      sense_s2 <= sense_s1;
      rate_s1  <= rate_detect_pins;
      rate_s2  <= rate_s1;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Bus line events
  assign scl_rise  = scl_s2 && !scl_p;
  assign scl_fall  = !scl_s2 && scl_p;
  assign bus_start = scl_s2 && scl_p && sda_p && !sda_s2;
  assign bus_stop  = scl_s2 && scl_p && !sda_p && sda_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] idle_q, idle_d;
  logic [7:0] eq_q, eq_d;
  logic [7:0] swing_q, swing_d;
  logic [4:0] emph_q, emph_d;
  logic [7:0] squelch_q, squelch_d;
  logic       present;
  logic       wr_en;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] shift_q, shift_d;

  // Register readback mux
  function automatic logic [7:0] reg_readback(input logic [7:0] addr);
    logic [7:0] rd;
    rd = 8'h00;
    unique case (addr)
      lane_cfg_pkg::ADDR_IDLE_DETECT: rd = idle_q;
      lane_cfg_pkg::ADDR_EQUALIZER:   rd = eq_q;
      lane_cfg_pkg::ADDR_SWING:       rd = swing_q;
      lane_cfg_pkg::ADDR_EMPHASIS: begin
        rd = {3'h0, emph_q};
        rd[lane_cfg_pkg::PRESENT_BIT] = present;                 // [RQ13]
        rd[lane_cfg_pkg::RATE_DET_LSB +: 2] = rate_s2;           // [RQ14]
      end
      lane_cfg_pkg::ADDR_SQUELCH:     rd = squelch_q;
      lane_cfg_pkg::ADDR_IDENTITY:
        rd = {lane_cfg_pkg::IDENT_VERSION, lane_cfg_pkg::IDENT_PART};  // [RQ20]
      default:                        rd = 8'h00;
    endcase
    return rd;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Management bus slave
  bus_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rw_q, rw_d;
  logic       first_q, first_d;
  logic       nack_q, nack_d;
  logic       oe_q, oe_d;

  // Byte framing, acknowledge and pointer handling
  always_comb begin
    logic [7:0] rd;
    rd      = reg_readback(ptr_q);
    state_d = state_q;
    cnt_d   = cnt_q;
    rw_d    = rw_q;
    first_d = first_q;
    nack_d  = nack_q;
    oe_d    = oe_q;
    ptr_d   = ptr_q;
    shift_d = shift_q;
    wr_en   = 1'b0;
    if (bus_start) begin
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2};
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == lane_cfg_pkg::BYTE_BITS) begin
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == BUS_ADDR) begin
                rw_d    = shift_q[0];
                first_d = 1'b1;
                oe_d    = 1'b1;
                state_d = ST_ACK;
              end else begin
                state_d = ST_IDLE;
              end
            end else begin
              if (first_q) begin
                ptr_d   = shift_q;
                first_d = 1'b0;
              end else begin
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
              oe_d    = 1'b1;
              state_d = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              shift_d = rd;
              oe_d    = !rd[7];
              ptr_d   = ptr_q + 8'h01;
              state_d = ST_READ;
            end else begin
              oe_d    = 1'b0;
              state_d = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == lane_cfg_pkg::BYTE_BITS) begin
              oe_d    = 1'b0;
              state_d = ST_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d    = !shift_q[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_d = sda_s2;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_d = ST_IDLE;
            end else begin
              shift_d = rd;
              oe_d    = !rd[7];
              ptr_d   = ptr_q + 8'h01;
              cnt_d   = 4'h0;
              state_d = ST_READ;
            end
          end
        end
      endcase
    end
  end

  // Bus state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      oe_q    <= 1'b0;
      ptr_q   <= 8'h00;
      shift_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rw_q    <= rw_d;
      first_q <= first_d;
      nack_q  <= nack_d;
      oe_q    <= oe_d;
      ptr_q   <= ptr_d;
      shift_q <= shift_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_comb begin
    idle_d    = idle_q;
    eq_d      = eq_q;
    swing_d   = swing_q;
    emph_d    = emph_q;
    squelch_d = squelch_q;
    if (wr_en) begin
      unique case (ptr_q)
        lane_cfg_pkg::ADDR_IDLE_DETECT: idle_d    = shift_q;  // [RQ1] [RQ7]
        lane_cfg_pkg::ADDR_EQUALIZER:   eq_d      = shift_q;  // [RQ8]
        lane_cfg_pkg::ADDR_SWING:       swing_d   = shift_q;  // [RQ9] [RQ10] [RQ12]
        lane_cfg_pkg::ADDR_EMPHASIS:
          emph_d = shift_q[lane_cfg_pkg::EMPH_WR_W-1:0];      // [RQ15]
        lane_cfg_pkg::ADDR_SQUELCH:     squelch_d = shift_q;  // [RQ16] [RQ17]
        default:                        idle_d    = idle_q;
      endcase
    end
  end

  // Register storage with documented defaults
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_q    <= lane_cfg_pkg::RST_IDLE_DETECT;
      eq_q      <= lane_cfg_pkg::RST_EQUALIZER;             // [RQ8]
      swing_q   <= lane_cfg_pkg::RST_SWING;                 // [RQ12]
      emph_q    <= lane_cfg_pkg::RST_EMPHASIS;              // [RQ15]
      squelch_q <= lane_cfg_pkg::RST_SQUELCH;               // [RQ16] [RQ17]
    end else begin
      idle_q    <= idle_d;
      eq_q      <= eq_d;
      swing_q   <= swing_d;
      emph_q    <= emph_d;
      squelch_q <= squelch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Far-end receiver detection
  lane_cfg_pkg::det_mode_t det_mode;

  // Register field alone picks the mode
  assign det_mode = lane_cfg_pkg::det_mode_t'(idle_q[lane_cfg_pkg::DET_MODE_LSB +: 2]);  // [RQ7]

  far_end_detect_seq #(
    .INTERVAL_CYCLES (INTERVAL_CYCLES)
  ) u_detect (
    .clock   (clock),
    .rst_n   (rst_n),
    .mode    (det_mode),
    .sense   (sense_s2),
    .probe   (rx_probe),
    .present (present),
    .term_50 (term_50_ohm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lane control outputs
  logic                   mute_q, mute_d;
  lane_cfg_pkg::lane_cfg_t cfg_q, cfg_d;

  // Idle selection and configuration fan-out
  always_comb begin
    if (idle_q[lane_cfg_pkg::IDLE_AUTO_BIT]) begin
      mute_d = !sig_s2;                                                  // [RQ1]
    end else begin
      mute_d = idle_q[lane_cfg_pkg::IDLE_SEL_BIT];                       // [RQ1] [RQ2]
    end
    cfg_d.sc_protect_en        = swing_q[lane_cfg_pkg::SC_PROT_BIT];     // [RQ9]
    cfg_d.rate_gen12           = swing_q[lane_cfg_pkg::RATE_SEL_BIT];    // [RQ10]
    cfg_d.output_swing_level   = swing_q[lane_cfg_pkg::SWING_LSB +: 3];  // [RQ12]
    cfg_d.deemphasis_level     = emph_q[lane_cfg_pkg::DEEMPH_LSB +: 3];  // [RQ15]
    cfg_d.equalizer_level      = eq_q;                                   // [RQ8]
    cfg_d.squelch_deassert_sel = squelch_q[lane_cfg_pkg::DEASSERT_LSB +: 2];  // [RQ16] [RQ18]
    cfg_d.squelch_assert_sel   = squelch_q[lane_cfg_pkg::ASSERT_LSB +: 2];    // [RQ17] [RQ18]
  end

  // Output registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mute_q  <= 1'b0;
      cfg_q   <= '0;
      sda_out <= 1'b0;
    end else begin
      mute_q  <= mute_d;
      cfg_q   <= cfg_d;
      sda_out <= 1'b0;
    end
  end

  assign output_mute = mute_q;
  assign cfg         = cfg_q;
  assign sda_oe      = oe_q;

endmodule
`default_nettype wire

/* File: hw/lane_cfg_pkg.sv */
// Operation
// RQ1: Automatic idle bit set means self idle detect; clear lets the mute bit decide.
// RQ2: Mute bit 1 puts the output in electrical idle; 0 keeps it active.
// RQ3: Detect mode 00 gives high-impedance input; 11 forces fixed 50 ohm termination.
// RQ4: Mode 01 probes every 12 ms and gives up after fifty attempts.
// RQ5: Mode 10 probes every 12 ms without limit until a receiver is found.
// RQ6: Automatic modes keep high impedance until detection, then switch to 50 ohm.
// RQ7: The detect mode field overrides the detect configuration pin.
// RQ8: Equalizer register holds an 8-bit boost code, reset value 0x2F.
// RQ9: Swing register bit 7 enables output short-circuit protection.
// RQ10: Rate bit 6 selects first/second generation when 1, third when 0; overrides pin.
// RQ11: Software keeps swing register bits 5 to 3 at 101.
// RQ12: Swing code 000..111 maps 0.7 V..1.4 V in 0.1 V steps; default 101.
// RQ13: Read-only emphasis bit 7 reports far-end receiver presence.
// RQ14: Read-only emphasis bits 6:5 report detected line rate.
// RQ15: Three-bit de-emphasis code selects 0 to -12 dB; default 010.
// RQ16: Threshold bits 3:2 pick the squelch de-assert level, default 00.
// RQ17: Threshold bits 1:0 pick the squelch assert level, default 00.
// RQ18: Threshold fields override the signal detect threshold pin.
// RQ19: Software writes zeros to other reserved bits and ignores their readback.
// RQ20: Identity register is read-only: 3-bit version, 5-bit part identifier.
`default_nettype none
package lane_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_IDLE_DETECT = 8'h40;
  localparam logic [7:0] ADDR_EQUALIZER   = 8'h41;
  localparam logic [7:0] ADDR_SWING       = 8'h42;
  localparam logic [7:0] ADDR_EMPHASIS    = 8'h43;
  localparam logic [7:0] ADDR_SQUELCH     = 8'h44;
  localparam logic [7:0] ADDR_IDENTITY    = 8'h51;

  // Reset values
  localparam logic [7:0] RST_IDLE_DETECT  = 8'h00;
  localparam logic [7:0] RST_EQUALIZER    = 8'h2f;
  localparam logic [7:0] RST_SWING        = 8'had;
  localparam logic [4:0] RST_EMPHASIS     = 5'h02;
  localparam logic [7:0] RST_SQUELCH      = 8'h00;

  // Field positions and widths
  localparam int IDLE_AUTO_BIT  = 5;
  localparam int IDLE_SEL_BIT   = 4;
  localparam int DET_MODE_LSB   = 2;
  localparam int SC_PROT_BIT    = 7;
  localparam int RATE_SEL_BIT   = 6;
  localparam int SWING_LSB      = 0;
  localparam int PRESENT_BIT    = 7;
  localparam int RATE_DET_LSB   = 5;
  localparam int DEEMPH_LSB     = 0;
  localparam int DEASSERT_LSB   = 2;
  localparam int ASSERT_LSB     = 0;
  localparam int EMPH_WR_W      = 5;

  // Identity fields; values are arbitrary
  localparam logic [2:0] IDENT_VERSION = 3'h1;
  localparam logic [4:0] IDENT_PART    = 5'h0a;

  // Management bus
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [6:0] DEF_BUS_ADDR   = 7'h18;

  // Far-end detect timing
  localparam longint CLOCK_HZ           = 64'd10000000;
  localparam longint DETECT_INTERVAL_MS = 64'd12;
  localparam longint DETECT_LIMIT_MS    = 64'd600;
  localparam int     DETECT_INTERVAL_CYCLES = int'(DETECT_INTERVAL_MS * CLOCK_HZ / 64'd1000);
  localparam logic [5:0] DETECT_ATTEMPTS = 6'(DETECT_LIMIT_MS / DETECT_INTERVAL_MS);

  // Far-end detect modes
  typedef enum logic [1:0] {
    DET_HIZ      = 2'h0,
    DET_LIMITED  = 2'h1,
    DET_ENDLESS  = 2'h2,
    DET_FIXED50  = 2'h3
  } det_mode_t;

  // Configuration handed to the analog lane
  typedef struct packed {
    logic       sc_protect_en;
    logic       rate_gen12;
    logic [2:0] output_swing_level;
    logic [2:0] deemphasis_level;
    logic [7:0] equalizer_level;
    logic [1:0] squelch_deassert_sel;
    logic [1:0] squelch_assert_sel;
  } lane_cfg_t;

endpackage
`default_nettype wire

/* File: hw/far_end_detect_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module far_end_detect_seq #(
  parameter int INTERVAL_CYCLES = lane_cfg_pkg::DETECT_INTERVAL_CYCLES
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire lane_cfg_pkg::det_mode_t mode,
  input  wire logic                    sense,
  output logic                         probe,
  output logic                         present,
  output logic                         term_50
);

  localparam int CNT_W = $clog2(INTERVAL_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INTERVAL_CYCLES - 1);

  lane_cfg_pkg::det_mode_t mode_q;
  logic [CNT_W-1:0]        cnt_q, cnt_d;
  logic [5:0]              tries_q, tries_d;
  logic                    probe_q, probe_d;
  logic                    present_q, present_d;
  logic                    term_q, term_d;

  ////////////////////////////////////////////////////////////////////////////
  // Probe scheduling and presence latch
  always_comb begin
    cnt_d     = cnt_q;
    tries_d   = tries_q;
    probe_d   = 1'b0;
    present_d = present_q;
    if (mode != mode_q) begin
      cnt_d     = '0;
      tries_d   = '0;
      present_d = 1'b0;
    end else begin
      unique case (mode)
        lane_cfg_pkg::DET_HIZ,
        lane_cfg_pkg::DET_FIXED50: begin
          present_d = 1'b0;                          // [RQ3]
        end
        lane_cfg_pkg::DET_LIMITED,
        lane_cfg_pkg::DET_ENDLESS: begin
          if (probe_q && sense) begin
            present_d = 1'b1;
          end else if (!present_q && (mode == lane_cfg_pkg::DET_ENDLESS ||
                       tries_q < lane_cfg_pkg::DETECT_ATTEMPTS)) begin
            if (cnt_q == CNT_LAST) begin
              cnt_d   = '0;
              probe_d = 1'b1;                        // [RQ4] [RQ5]
              if (mode == lane_cfg_pkg::DET_LIMITED) begin
                tries_d = tries_q + 6'h01;           // [RQ4]
              end
            end else begin
              cnt_d = cnt_q + CNT_W'(1);
            end
          end
        end
      endcase
    end
    // Fixed mode 50 ohm; otherwise high impedance until found, then 50 ohm
    term_d = (mode == lane_cfg_pkg::DET_FIXED50) ||
             (mode != lane_cfg_pkg::DET_HIZ && present_d);  // [RQ3] [RQ6]
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= lane_cfg_pkg::DET_HIZ;
      cnt_q     <= '0;
      tries_q   <= '0;
      probe_q   <= 1'b0;
      present_q <= 1'b0;
      term_q    <= 1'b0;
    end else begin
      mode_q    <= mode;
      cnt_q     <= cnt_d;
      tries_q   <= tries_d;
      probe_q   <= probe_d;
      present_q <= present_d;
      term_q    <= term_d;
    end
  end

  assign probe   = probe_q;
  assign present = present_q;
  assign term_50 = term_q;

endmodule
`default_nettype wire

/* File: tb/mgmt_bus_host.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Bus host model: frames and bytes, MSB first, all lines moved on falling edges
module mgmt_bus_host (
  input  wire logic clock,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // Idle bus, both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Start or repeated start: data drops while clock is high
  task automatic start();
    sda_drv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_drv = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask

  // Stop: data rises while clock is high
  task automatic stop();
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_drv = 1'b1;
    tick(8);
  endtask

  // One bit; sampled mid high phase, after device settling
  task automatic bit_xfer(input logic b, output logic r);
    tick(4);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_wire;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack);
  endtask

  // Releases data for eight bits, then acks or ends with nack
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, r);
  endtask
endmodule
`default_nettype wire

/* File: tb/lane_cfg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module lane_cfg_checker #(
  parameter int INTERVAL_CYCLES = 20
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    scl_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  input wire logic                    output_mute,
  input wire logic                    rx_probe,
  input wire logic                    term_50_ohm,
  input wire lane_cfg_pkg::lane_cfg_t cfg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  int gap_q;
  int gap_d;

  // Cycles since the last probe, saturating
  always_comb begin
    gap_d = gap_q;
    if (rx_probe) begin
      gap_d = 0;
    end else if (gap_q < INTERVAL_CYCLES) begin
      gap_d = gap_q + 1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= INTERVAL_CYCLES;
    end else begin
      gap_q <= gap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_probe_single_cycle: assert property (rx_probe |=> !rx_probe)
    else $error("probe pulse longer than one cycle");
  a_probe_interval_kept: assert property (rx_probe |-> gap_q >= INTERVAL_CYCLES - 1)
    else $error("probes closer than the interval");
  a_probe_before_term: assert property (rx_probe |-> !term_50_ohm)
    else $error("probe while terminated");
  a_sda_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_oe_rise_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("device pulls data while clock high");
  a_oe_fall_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("device releases data while clock high");
  a_reset_quiet_out: assert property ($rose(rst_n) |-> cfg == '0 && !sda_oe && !rx_probe && !output_mute)
    else $error("outputs active during reset");
  a_cfg_defaults_out: assert property ($rose(rst_n) |=> cfg.equalizer_level == 8'h2f
    && cfg.output_swing_level == 3'h5 && cfg.deemphasis_level == 3'h2 && cfg.sc_protect_en && !cfg.rate_gen12)
    else $error("configuration defaults wrong");
  a_cfg_bus_only: assert property ($changed(cfg) |-> !scl_in || !$past(rst_n, 2))
    else $error("configuration changed outside a bus write");

  // Main scenarios
  c_probe_seen: cover property (rx_probe);
  c_term_on: cover property ($rose(term_50_ohm));
  c_mute_on: cover property ($rose(output_mute));
endmodule
`default_nettype wire

/* File: tb/lane_channel_config_registers_test.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module lane_channel_config_registers_test;
  localparam int         INTERVAL = 20;
  localparam logic [6:0] DEV      = lane_cfg_pkg::DEF_BUS_ADDR;

  logic                    clock;
  logic                    rst_n;
  logic                    scl;
  logic                    sda_drv;
  logic                    sda_wire;
  logic                    sda_out;
  logic                    sda_oe;
  logic                    line_signal_present;
  logic                    far_end_sense;
  logic [1:0]              rate_detect_pins;
  logic                    output_mute;
  logic                    rx_probe;
  logic                    term_50_ohm;
  lane_cfg_pkg::lane_cfg_t cfg;
  int                      failures;
  int                      samples_checked;
  int                      probe_count;

  // Open-drain data line with pull-up
  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);

  lane_channel_config_registers #(.BUS_ADDR(DEV), .INTERVAL_CYCLES(INTERVAL)) dut (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .line_signal_present(line_signal_present), .far_end_sense(far_end_sense),
    .rate_detect_pins(rate_detect_pins), .output_mute(output_mute), .rx_probe(rx_probe),
    .term_50_ohm(term_50_ohm), .cfg(cfg));

  mgmt_bus_host host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

  // Clock and probe counter
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) begin
    if (rx_probe === 1'b1) probe_count++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic ack;
    host.start();
    host.byte_wr({DEV, 1'b0}, ack);
    chk(ack, 1'b0);
    host.byte_wr(a, ack);
    chk(ack, 1'b0);
    host.byte_wr(d, ack);
    chk(ack, 1'b0);
    host.stop();
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    logic ack;
    logic [7:0] d;
    host.start();
    host.byte_wr({DEV, 1'b0}, ack);
    chk(ack, 1'b0);
    host.byte_wr(a, ack);
    host.start();
    host.byte_wr({DEV, 1'b1}, ack);
    chk(ack, 1'b0);
    host.byte_rd(1'b1, d);
    host.stop();
    chk(d, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    expect_reg(8'h40, 8'h00);
    expect_reg(8'h41, 8'h2f);
    expect_reg(8'h42, 8'had);
    expect_reg(8'h43, {1'b0, rate_detect_pins, 5'h02});
    expect_reg(8'h44, 8'h00);
    expect_reg(8'h51, {lane_cfg_pkg::IDENT_VERSION, lane_cfg_pkg::IDENT_PART});
    expect_reg(8'h50, 8'h00);
    chk(cfg, {1'b1, 1'b0, 3'h5, 3'h2, 8'h2f, 4'h0});
  endtask

  // Read-only places ignore writes; status follows the rate pins
  task automatic t_status();
    logic [1:0] codes [3];
    codes = '{2'h0, 2'h1, 2'h3};
    wr_reg(8'h51, 8'h00);
    expect_reg(8'h51, {lane_cfg_pkg::IDENT_VERSION, lane_cfg_pkg::IDENT_PART});
    wr_reg(8'h43, 8'he7);
    for (int i = 0; i < 3; i++) begin
      rate_detect_pins = codes[i];
      repeat (8) @(negedge clock);
      expect_reg(8'h43, {1'b0, codes[i], 5'h07});
    end
    chk(cfg.deemphasis_level, 3'h7);
  endtask

  task automatic t_fields();
    logic ack;
    logic [7:0] d;
    wr_reg(8'h41, 8'h10);
    chk(cfg.equalizer_level, 8'h10);
    wr_reg(8'h42, 8'h2b);
    expect_reg(8'h42, 8'h2b);
    chk({cfg.sc_protect_en, cfg.rate_gen12, cfg.output_swing_level}, 5'h03);
    wr_reg(8'h44, 8'h0e);
    chk({cfg.squelch_deassert_sel, cfg.squelch_assert_sel}, 4'he);
    // Sequential read: master ack moves on to the next register
    host.start();
    host.byte_wr({DEV, 1'b0}, ack);
    host.byte_wr(8'h41, ack);
    host.start();
    host.byte_wr({DEV, 1'b1}, ack);
    host.byte_rd(1'b0, d);
    chk(d, 8'h10);
    host.byte_rd(1'b1, d);
    host.stop();
    chk(d, 8'h2b);
    // A foreign address gets no acknowledge
    host.start();
    host.byte_wr({DEV ^ 7'h01, 1'b0}, ack);
    chk(ack, 1'b1);
    host.stop();
  endtask

  task automatic t_mute();
    wr_reg(8'h40, 8'h10);
    chk(output_mute, 1'b1);
    wr_reg(8'h40, 8'h00);
    chk(output_mute, 1'b0);
    wr_reg(8'h40, 8'h30);
    repeat (8) @(negedge clock);
    chk(output_mute, 1'b0);
    line_signal_present = 1'b0;
    repeat (8) @(negedge clock);
    chk(output_mute, 1'b1);
    line_signal_present = 1'b1;
  endtask

  task automatic t_detect();
    probe_count = 0;
    wr_reg(8'h40, 8'h0c);
    repeat (3 * INTERVAL) @(negedge clock);
    chk({probe_count[7:0], term_50_ohm}, 9'h001);
    wr_reg(8'h40, 8'h00);
    chk(term_50_ohm, 1'b0);
    probe_count = 0;
    wr_reg(8'h40, 8'h04);
    repeat (60 * INTERVAL) @(negedge clock);
    chk({probe_count[7:0], term_50_ohm}, {8'd50, 1'b0});
    probe_count = 0;
    wr_reg(8'h40, 8'h08);
    repeat (60 * INTERVAL) @(negedge clock);
    chk(probe_count > 50, 1'b1);
    far_end_sense = 1'b1;
    for (int i = 0; i < 3 * INTERVAL && term_50_ohm !== 1'b1; i++) @(negedge clock);
    chk(term_50_ohm, 1'b1);
    expect_reg(8'h43, {1'b1, rate_detect_pins, 5'h07});
    probe_count = 0;
    repeat (3 * INTERVAL) @(negedge clock);
    chk(probe_count, 0);
    wr_reg(8'h40, 8'h00);
    chk(term_50_ohm, 1'b0);
    expect_reg(8'h43, {1'b0, rate_detect_pins, 5'h07});
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    line_signal_present = 1'b1;
    far_end_sense = 1'b0;
    rate_detect_pins = 2'h1;
    failures = 0;
    samples_checked = 0;
    probe_count = 0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    t_reset_values();
    t_status();
    t_fields();
    t_mute();
    t_detect();
    tally_and_finish();
  end

  // Watchdog
  initial begin
    repeat (80000) @(posedge clock);
    failures++;
    tally_and_finish();
  end
endmodule

bind lane_channel_config_registers lane_cfg_checker #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) watch (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .output_mute(output_mute), .rx_probe(rx_probe), .term_50_ohm(term_50_ohm), .cfg(cfg));
`default_nettype wire
